// File: hbc_host_model.sv
/*
 * Behavioural host microcontroller on the register bus.
 * Assumes one clock; the bench calls xfer once per transfer.
 */
module hbc_host_model (
    input  wire logic        clk,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [20:0]      paddr,
    output logic [31:0]      pwdata,
    output logic [3:0]       pstrb
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] strb = 4'hF;

    initial {psel, penable, pwrite, paddr, pwdata, pstrb} = 63'h0;

    task automatic xfer(input logic w, input logic [20:0] a,
                        input logic [31:0] d, output logic [31:0] q,
                        output logic e);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= strb;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // A released bus must not keep showing the last word.
        pwdata <= ~d;
    endtask
endmodule

// File: hbc_irq_pulse.sv
/*
 * Stretches an interrupt trigger into a request of programmable length.
 * Assumes the trigger and length come from logic on the same clock.
 */
module hbc_irq_pulse (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       trigger,
    input  wire logic [5:0] irq_pulse_cycles,
    output logic            irq
);

    logic [5:0] remaining;
    logic [5:0] next_remaining;

    ////////////////////////////////////////////////////////////////////////
    // A trigger reloads the count, so a held level keeps the request up.
    // request length count
    assign next_remaining = trigger ? irq_pulse_cycles :
                            (remaining != 6'h00) ? remaining - 6'h01 :
                            6'h00;
    assign irq = (remaining != 6'h00);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            remaining <= 6'h00;
        end else begin
            remaining <= next_remaining;
        end
    end

endmodule

// File: hbc_pkg.sv
/*
 * Shared constants and carrier types of the host bus control registers.
 * Assumes a 32-bit APB register bus with 21-bit byte addresses.
 */
package hbc_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register byte offsets.
    localparam logic [20:0] OFS_COMMAND_WORD     = 21'h00_0000;
    localparam logic [20:0] OFS_INPUT_FIFO_PORT  = 21'h00_0004;
    localparam logic [20:0] OFS_OUTPUT_FIFO_PORT = 21'h00_0008;
    localparam logic [20:0] OFS_EVENT_FLAGS      = 21'h00_000C;
    localparam logic [20:0] OFS_EVENT_FLAGS_CLR  = 21'h00_0010;
    localparam logic [20:0] OFS_EVENT_FLAGS_SET  = 21'h00_0014;
    localparam logic [20:0] OFS_IRQ_MASK         = 21'h00_0018;
    localparam logic [20:0] OFS_IRQ_MASK_CLR     = 21'h00_001C;
    localparam logic [20:0] OFS_IRQ_MASK_SET     = 21'h00_0020;
    localparam logic [20:0] OFS_IRQ_TRIGGER_TYPE = 21'h00_0024;
    localparam logic [20:0] OFS_IRQ_PULSE_LENGTH = 21'h00_0028;
    localparam logic [20:0] OFS_READY_TO_CONTROL = 21'h00_002C;
    localparam logic [20:0] OFS_READY_TO_ADDRESS = 21'h00_0030;
    localparam logic [20:0] OFS_BLOCK_CONFIG     = 21'h00_0038;
    localparam logic [20:0] OFS_ENGINE_PARAM     = 21'h00_003C;

    ////////////////////////////////////////////////////////////////////////
    // Reset values.
    localparam logic [7:0]  RST_COMMAND_CODE     = 8'hFF;
    localparam logic [23:0] RST_COMMAND_PARAM    = 24'h00_0000;
    localparam logic [31:0] RST_EVENT_FLAGS      = 32'h2040_0000;
    localparam logic [31:0] RST_IRQ_MASK         = 32'h0000_0000;
    localparam logic [31:0] RST_IRQ_TRIGGER_TYPE = 32'h0000_0000;
    localparam logic [5:0]  RST_IRQ_PULSE_CYCLES = 6'h10;
    localparam logic [7:0]  RST_READY_TO_LENGTH  = 8'hFF;
    localparam logic        RST_READY_TO_ENABLE  = 1'b1;
    localparam logic [20:0] RST_READY_TO_ADDRESS = 21'h00_0000;
    localparam logic [31:0] RST_ENGINE_PARAM     = 32'h0000_0000;

    ////////////////////////////////////////////////////////////////////////
    // Field positions.
    localparam int READY_TO_ENABLE_BIT = 8;
    localparam int READBACK_SELECT_BIT = 0;
    localparam int TIMEOUT_FLAG_BIT    = 2;

    ////////////////////////////////////////////////////////////////////////
    // Carrier types.
    typedef struct packed {
        logic [23:0] command_parameter;
        logic [7:0]  code;
    } hbc_command_t;

    typedef struct packed {
        logic        valid;
        logic [31:0] data;
    } hbc_word_t;

endpackage

// File: hbc_ready_timeout.sv
/*
 * Counts the cycles of a stalled bus access and flags its expiry.
 * Assumes the wait level comes from logic on the same clock.
 */
module hbc_ready_timeout (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       waiting,
    input  wire logic       ready_timeout_enable,
    input  wire logic [7:0] timeout_cycles,
    output logic            expired
);

    logic [7:0] count;
    logic [7:0] next_count;

    ////////////////////////////////////////////////////////////////////////
    // The count restarts for every access, so one slow access never
    // shortens the allowance of the next.
    assign next_count = waiting ? count + 8'h01 : 8'h00;

    assign expired = ready_timeout_enable & waiting &
                     (count == timeout_cycles);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count <= 8'h00;
        end else begin
            count <= next_count;
        end
    end

endmodule

// File: hbc_regs.sv
/*
 * APB register bank of the host bus controller: command word with
 * shadow copy, FIFO ports, event flags, interrupt mask and request,
 * bus ready timeout with captured address.
 * Assumes an APB master on CLK, a command engine that reports when a
 * command runs or starts, and FIFOs that give ready and valid levels.
 */
// What this block does
// - command code resets FF, parameter zero
// - shadow copy frozen while command runs
// - readback select picks host or working engine parameter
// - lockable writes ignored under master switch
// - flags writable, reset 20400000, hardware changes
// - clear alias clears written ones
// - set alias sets written ones
// - mask gates flags, resets zero
// - mask clear alias clears written ones
// - mask set alias sets written ones
// - trigger type picks edge or level
// - request lasts pulse length clocks after the last trigger
// - timeout expires after length clocks
// - timeout enable bit resets to one
// - timed-out address captured, resets zero
// - input FIFO port word writes only
// - output FIFO port word reads only
module hbc_regs (
    input  wire logic               CLK,
    input  wire logic               RST_N,
    input  wire logic               PSEL,
    input  wire logic               PENABLE,
    input  wire logic               PWRITE,
    input  wire logic [20:0]        PADDR,
    input  wire logic [31:0]        PWDATA,
    input  wire logic [3:0]         PSTRB,
    output logic      [31:0]        PRDATA,
    output logic                    PREADY,
    output logic                    PSLVERR,
    input  wire logic [31:0]        FLAG_SET,
    input  wire logic [31:0]        FLAG_CLR,
    input  wire logic               CMD_RUNNING,
    input  wire logic               CMD_START,
    input  wire logic               GRAPHICS_MASTER_SWITCH,
    output hbc_pkg::hbc_command_t   CMD_WORD,
    output logic                    CMD_WRITTEN,
    output logic      [31:0]        ENGINE_PARAM,
    output hbc_pkg::hbc_word_t      IN_FIFO_WRITE,
    input  wire logic               IN_FIFO_READY,
    input  wire logic [31:0]        OUT_FIFO_DATA,
    input  wire logic               OUT_FIFO_VALID,
    output logic                    OUT_FIFO_POP,
    output logic      [31:0]        EVENT_FLAGS,
    output logic                    IRQ
);

    ////////////////////////////////////////////////////////////////////////
    // Register state.
    hbc_pkg::hbc_command_t command_host;
    hbc_pkg::hbc_command_t command_work;
    logic [31:0]           engine_host;
    logic [31:0]           engine_work;
    logic [31:0]           event_flags;
    logic [31:0]           flags_prev;
    logic [31:0]           irq_mask;
    logic [31:0]           irq_trigger_type;
    logic [5:0]            irq_pulse_cycles;
    logic [7:0]            timeout_cycles;
    logic                  ready_timeout_enable;
    logic [20:0]           ready_timeout_address;
    logic                  readback_select;
    logic                  cmd_written;

    ////////////////////////////////////////////////////////////////////////
    // Address decode.
    wire hit_cmd  = (PADDR == hbc_pkg::OFS_COMMAND_WORD);
    wire hit_input_fifo_port = (PADDR == hbc_pkg::OFS_INPUT_FIFO_PORT);
    wire hit_output_fifo_port = (PADDR == hbc_pkg::OFS_OUTPUT_FIFO_PORT);
    wire hit_flags = (PADDR == hbc_pkg::OFS_EVENT_FLAGS);
    wire hit_fclr = (PADDR == hbc_pkg::OFS_EVENT_FLAGS_CLR);
    wire hit_fset = (PADDR == hbc_pkg::OFS_EVENT_FLAGS_SET);
    wire hit_mask = (PADDR == hbc_pkg::OFS_IRQ_MASK);
    wire hit_mclr = (PADDR == hbc_pkg::OFS_IRQ_MASK_CLR);
    wire hit_mset = (PADDR == hbc_pkg::OFS_IRQ_MASK_SET);
    wire hit_trig = (PADDR == hbc_pkg::OFS_IRQ_TRIGGER_TYPE);
    wire hit_plen = (PADDR == hbc_pkg::OFS_IRQ_PULSE_LENGTH);
    wire hit_toc  = (PADDR == hbc_pkg::OFS_READY_TO_CONTROL);
    wire hit_toa  = (PADDR == hbc_pkg::OFS_READY_TO_ADDRESS);
    wire hit_cfg  = (PADDR == hbc_pkg::OFS_BLOCK_CONFIG);
    wire hit_eng  = (PADDR == hbc_pkg::OFS_ENGINE_PARAM);

    wire hit_any = hit_cmd | hit_input_fifo_port | hit_output_fifo_port | hit_flags |
                   hit_fclr | hit_fset | hit_mask | hit_mclr |
                   hit_mset | hit_trig | hit_plen | hit_toc |
                   hit_toa | hit_cfg | hit_eng;

    ////////////////////////////////////////////////////////////////////////
    // Access classification.
    wire access     = PSEL & PENABLE;
    wire full_word  = (PSTRB == 4'hF);

    wire bad_input_fifo_port  = hit_input_fifo_port & (~PWRITE | ~full_word);
    wire bad_output_fifo_port  = hit_output_fifo_port & PWRITE;
    // Read-only address register refuses writes.
    wire bad_toa    = hit_toa & PWRITE;
    // Byte-lane writes are refused everywhere to keep aliases exact.
    wire bad_lanes  = PWRITE & ~full_word;
    wire bad_access = ~hit_any | bad_input_fifo_port | bad_output_fifo_port | bad_toa |
                      bad_lanes;

    ////////////////////////////////////////////////////////////////////////
    // FIFO stall and bus ready timeout.
    wire fifo_stall = access & ~bad_access &
                      ((hit_input_fifo_port & ~IN_FIFO_READY) |
                       (hit_output_fifo_port & ~OUT_FIFO_VALID));
    logic timeout_expired;

    hbc_ready_timeout u_timeout (
        .clk                  (CLK),
        .rst_n                (RST_N),
        .waiting              (fifo_stall),
        .ready_timeout_enable (ready_timeout_enable),
        .timeout_cycles       (timeout_cycles),
        .expired              (timeout_expired)
    );

    assign PREADY  = ~fifo_stall | timeout_expired;
    assign PSLVERR = access & (bad_access | timeout_expired);

    wire done     = access & PREADY;
    wire good     = done & ~bad_access & ~timeout_expired;
    wire wr_good  = good & PWRITE;
    wire rd_good  = good & ~PWRITE;

    ////////////////////////////////////////////////////////////////////////
    // FIFO ports: the push and pop happen at the completing edge only.
    assign IN_FIFO_WRITE.valid = wr_good & hit_input_fifo_port;
    assign IN_FIFO_WRITE.data  = PWDATA;
    assign OUT_FIFO_POP        = rd_good & hit_output_fifo_port;

    ////////////////////////////////////////////////////////////////////////
    // Write strobes.
    wire wr_cmd   = wr_good & hit_cmd;
    wire wr_flags = wr_good & hit_flags;
    wire wr_fclr  = wr_good & hit_fclr;
    wire wr_fset  = wr_good & hit_fset;
    wire wr_mask  = wr_good & hit_mask;
    wire wr_mclr  = wr_good & hit_mclr;
    wire wr_mset  = wr_good & hit_mset;
    wire wr_trig  = wr_good & hit_trig;
    wire wr_plen  = wr_good & hit_plen;
    wire wr_toc   = wr_good & hit_toc;
    wire wr_cfg   = wr_good & hit_cfg;
    wire wr_eng   = wr_good & hit_eng & ~GRAPHICS_MASTER_SWITCH;

    ////////////////////////////////////////////////////////////////////////
    // Shadow copies follow the host copy except while a command runs;
    // a command start takes the value written in the meantime.
    // shadow update point
    wire shadow_load = CMD_START | ~CMD_RUNNING;

    hbc_pkg::hbc_command_t next_command_host;
    hbc_pkg::hbc_command_t next_command_work;
    logic [31:0]           next_engine_host;
    logic [31:0]           next_engine_work;

    assign next_command_host = wr_cmd ? hbc_pkg::hbc_command_t'(PWDATA)
                                      : command_host;
    assign next_command_work = shadow_load ? command_host : command_work;
    assign next_engine_host  = wr_eng ? PWDATA : engine_host;
    assign next_engine_work  = shadow_load ? engine_host : engine_work;

    ////////////////////////////////////////////////////////////////////////
    // Event flags: hardware sets win over every clear in the same cycle.
    logic [31:0] hw_set;
    logic [31:0] flags_base;
    logic [31:0] flags_clear;
    logic [31:0] flags_set;
    logic [31:0] next_event_flags;

    assign hw_set = FLAG_SET |
                    ({31'h0000_0000, timeout_expired} <<
                     hbc_pkg::TIMEOUT_FLAG_BIT);
    assign flags_base  = wr_flags ? PWDATA : event_flags;
    assign flags_clear = (wr_fclr ? PWDATA : 32'h0000_0000) | FLAG_CLR;
    assign flags_set   = (wr_fset ? PWDATA : 32'h0000_0000) | hw_set;
    assign next_event_flags = (flags_base & ~flags_clear) | flags_set;

    ////////////////////////////////////////////////////////////////////////
    // Interrupt mask with its aliases.
    logic [31:0] next_irq_mask;

    assign next_irq_mask =
        ((wr_mask ? PWDATA : irq_mask) &
         ~(wr_mclr ? PWDATA : 32'h0000_0000)) |
        (wr_mset ? PWDATA : 32'h0000_0000);

    ////////////////////////////////////////////////////////////////////////
    // Per-flag trigger, edge or level, gated by the mask.
    logic [31:0] flag_trigger;

    genvar gi;
    generate
        for (gi = 0; gi < 32; gi = gi + 1) begin : g_trig
            assign flag_trigger[gi] = irq_trigger_type[gi]
                ? (event_flags[gi] & ~flags_prev[gi])
                : event_flags[gi];
        end
    endgenerate

    wire irq_trigger = |(flag_trigger & irq_mask);

    hbc_irq_pulse u_irq (
        .clk              (CLK),
        .rst_n            (RST_N),
        .trigger          (irq_trigger),
        .irq_pulse_cycles (irq_pulse_cycles),
        .irq              (IRQ)
    );

    ////////////////////////////////////////////////////////////////////////
    // Read data mux.
    wire [31:0] engine_readback = readback_select ? engine_work
                                                  : engine_host;
    wire [31:0] rd_cmd  = {command_host.command_parameter,
                           command_host.code};
    wire [31:0] rd_plen = {26'h000_0000, irq_pulse_cycles};
    wire [31:0] rd_toc  = {23'h00_0000, ready_timeout_enable,
                           timeout_cycles};
    wire [31:0] rd_toa  = {11'h000, ready_timeout_address};
    wire [31:0] rd_cfg  = {31'h0000_0000, readback_select};

    assign PRDATA = ~rd_good ? 32'h0000_0000 :
                    hit_cmd ? rd_cmd :
                    hit_output_fifo_port ? OUT_FIFO_DATA :
                    (hit_flags | hit_fclr | hit_fset) ? event_flags :
                    (hit_mask | hit_mclr | hit_mset) ? irq_mask :
                    hit_trig ? irq_trigger_type :
                    hit_plen ? rd_plen :
                    hit_toc ? rd_toc :
                    hit_toa ? rd_toa :
                    hit_cfg ? rd_cfg :
                    hit_eng ? engine_readback :
                    32'h0000_0000;

    ////////////////////////////////////////////////////////////////////////
    // Outputs from the working copies, the write pulse and the event flags.
    assign CMD_WORD     = command_work;
    assign CMD_WRITTEN  = cmd_written;
    assign ENGINE_PARAM = engine_work;
    assign EVENT_FLAGS  = event_flags;

    ////////////////////////////////////////////////////////////////////////
    // Command and shadowed registers.
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            command_host <= {hbc_pkg::RST_COMMAND_PARAM,
                             hbc_pkg::RST_COMMAND_CODE};
            command_work <= {hbc_pkg::RST_COMMAND_PARAM,
                             hbc_pkg::RST_COMMAND_CODE};
            engine_host  <= hbc_pkg::RST_ENGINE_PARAM;
            engine_work  <= hbc_pkg::RST_ENGINE_PARAM;
            cmd_written  <= 1'b0;
        end else begin
            command_host <= next_command_host;
            command_work <= next_command_work;
            engine_host  <= next_engine_host;
            engine_work  <= next_engine_work;
            cmd_written  <= wr_cmd;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Flags, mask and trigger type.
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            event_flags      <= hbc_pkg::RST_EVENT_FLAGS;
            flags_prev       <= hbc_pkg::RST_EVENT_FLAGS;
            irq_mask         <= hbc_pkg::RST_IRQ_MASK;
            irq_trigger_type <= hbc_pkg::RST_IRQ_TRIGGER_TYPE;
        end else begin
            event_flags      <= next_event_flags;
            flags_prev       <= event_flags;
            irq_mask         <= next_irq_mask;
            if (wr_trig) begin
                irq_trigger_type <= PWDATA;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pulse length, timeout control and block configuration.
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            irq_pulse_cycles     <= hbc_pkg::RST_IRQ_PULSE_CYCLES;
            timeout_cycles       <= hbc_pkg::RST_READY_TO_LENGTH;
            ready_timeout_enable <= hbc_pkg::RST_READY_TO_ENABLE;
            readback_select      <= 1'b0;
        end else begin
            if (wr_plen) begin
                irq_pulse_cycles <= PWDATA[5:0];
            end
            if (wr_toc) begin
                timeout_cycles       <= PWDATA[7:0];
                ready_timeout_enable <=
                    PWDATA[hbc_pkg::READY_TO_ENABLE_BIT];
            end
            if (wr_cfg) begin
                readback_select <= PWDATA[hbc_pkg::READBACK_SELECT_BIT];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Address of the access that ran out of time.
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            ready_timeout_address <= hbc_pkg::RST_READY_TO_ADDRESS;
        end else if (access & timeout_expired) begin
            ready_timeout_address <= PADDR;
        end
    end

endmodule

// File: hbc_regs_properties.sv
/*
 * Concurrent checks on the ports of the host bus control registers.
 * Assumes it is bound into hbc_regs and sees only that module's ports.
 */
module hbc_regs_properties (
    input wire logic        CLK,
    input wire logic        RST_N,
    input wire logic        PSEL,
    input wire logic        PENABLE,
    input wire logic        PWRITE,
    input wire logic [20:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [3:0]  PSTRB,
    input wire logic [31:0] PRDATA,
    input wire logic        PREADY,
    input wire logic        PSLVERR,
    input wire logic [31:0] FLAG_SET,
    input wire logic [31:0] FLAG_CLR,
    input wire logic        CMD_RUNNING,
    input wire logic        CMD_START,
    input wire logic        GRAPHICS_MASTER_SWITCH,
    input wire logic [31:0] CMD_WORD,
    input wire logic [31:0] ENGINE_PARAM,
    input wire logic [32:0] IN_FIFO_WRITE,
    input wire logic [31:0] OUT_FIFO_DATA,
    input wire logic        OUT_FIFO_POP,
    input wire logic [31:0] EVENT_FLAGS,
    input wire logic        IRQ
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_N);

    ////////////////////////////////////////////////////////////////////////
    wire acc = PSEL && PENABLE && PREADY && !PSLVERR;
    wire wok = acc && PWRITE && PSTRB == 4'hF;
    wire hw0 = FLAG_SET == 32'h0000_0000 && FLAG_CLR == 32'h0000_0000;
    logic [8:0] tcfg;
    logic [5:0] plen;
    logic [7:0] wcnt;
    logic [6:0] run;

    // Length fields are followed from completed writes only.
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            tcfg <= 9'h1FF;
            plen <= 6'h10;
        end else if (wok && PADDR == 21'h00_002C) begin
            tcfg <= PWDATA[8:0];
        end else if (wok && PADDR == 21'h00_0028) begin
            plen <= PWDATA[5:0];
        end
    end

    // The run counter saturates, since a level interrupt may stay up for long; the wait counter wraps.
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            wcnt <= 8'h00;
            run  <= 7'h00;
        end else begin
            wcnt <= (PSEL && PENABLE && !PREADY) ? wcnt + 8'h01 : 8'h00;
            run  <= IRQ ? run + {6'h00, run != 7'h7F} : 7'h00;
        end
    end

    sequence stall_s;
        PSEL && PENABLE && !PREADY;
    endsequence
    sequence forced_exit_s;
        stall_s ##1 (PREADY && PSLVERR);
    endsequence

    cmd_reset_a: assert property (
        $rose(RST_N) |-> CMD_WORD == 32'h0000_00FF
        && EVENT_FLAGS == 32'h2040_0000) else $error("bad reset");
    shadow_hold_a: assert property (
        CMD_RUNNING && !CMD_START |=> $stable(CMD_WORD))
        else $error("shadow moved");
    engine_lock_a: assert property (
        wok && PADDR == 21'h00_003C && GRAPHICS_MASTER_SWITCH
        |=> $stable(ENGINE_PARAM) [*2]) else $error("lock lost");
    flag_write_a: assert property (
        wok && PADDR == 21'h00_000C && hw0
        |=> EVENT_FLAGS == $past(PWDATA)) else $error("write lost");
    flag_clear_a: assert property (
        wok && PADDR == 21'h00_0010 && hw0
        |=> (EVENT_FLAGS & $past(PWDATA)) == 32'h0000_0000)
        else $error("not cleared");
    flag_set_a: assert property (
        wok && PADDR == 21'h00_0014
        |=> (EVENT_FLAGS & $past(PWDATA)) == $past(PWDATA))
        else $error("not set");
    irq_length_a: assert property (
        $fell(IRQ) |-> run >= {1'b0, plen}) else $error("short irq");
    ready_timeout_a: assert property (
        stall_s |-> !tcfg[8] || wcnt < tcfg[7:0])
        else $error("long stall");
    timeout_flag_a: assert property (
        forced_exit_s |=> EVENT_FLAGS[2]) else $error("no flag");
    fifo_push_a: assert property (
        IN_FIFO_WRITE[32] |-> wok && PADDR == 21'h00_0004
        && IN_FIFO_WRITE[31:0] == PWDATA) else $error("stray push");
    fifo_pop_a: assert property (
        OUT_FIFO_POP |-> acc && !PWRITE && PADDR == 21'h00_0008
        && PRDATA == OUT_FIFO_DATA) else $error("stray pop");
endmodule

// File: tb.sv
/*
 * Self-checking bench of the host bus control registers.
 * Assumes the host model drives the bus and this module the rest.
 */
module tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk = 1'b0, rst_n = 1'b0, running = 1'b0, start = 1'b0;
    logic lock = 1'b0, in_rdy = 1'b0, out_vld = 1'b0, e, irq, cmd_wr;
    logic psel, penable, pwrite, pready, pslverr;
    logic [31:0] fset = 32'h0000_0000, fclr = 32'h0000_0000;
    logic [31:0] out_data = 32'h0000_0000, pwdata, prdata, eparam, q;
    logic [20:0] paddr;
    logic [3:0] pstrb;
    hbc_pkg::hbc_command_t cmd_word;
    int num_errors = 0, comparisons = 0, n;

    hbc_regs u_dut (.CLK(clk), .RST_N(rst_n), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
        .PWDATA(pwdata), .PSTRB(pstrb), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .FLAG_SET(fset), .FLAG_CLR(fclr),
        .CMD_RUNNING(running), .CMD_START(start),
        .GRAPHICS_MASTER_SWITCH(lock), .CMD_WORD(cmd_word),
        .CMD_WRITTEN(cmd_wr), .ENGINE_PARAM(eparam), .IN_FIFO_WRITE(),
        .IN_FIFO_READY(in_rdy), .OUT_FIFO_DATA(out_data),
        .OUT_FIFO_VALID(out_vld), .OUT_FIFO_POP(), .EVENT_FLAGS(),
        .IRQ(irq));
    hbc_host_model u_host (.clk(clk), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb));

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string s, input logic [31:0] v, x);
        comparisons++;
        if (v !== x) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", s, x, v);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, xe = 0);
        u_host.xfer(1'b1, {13'h0000, a}, d, q, e);
        check("write error", {31'h0, e}, xe);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] x, xe = 0);
        u_host.xfer(1'b0, {13'h0000, a}, 32'h0000_0000, q, e);
        check("read data", q, x);
        check("read error", {31'h0, e}, xe);
    endtask
    task automatic t_reset();
        rd(8'h00, 8'hFF);
        rd(8'h0C, 32'h2040_0000);
        rd(8'h18, 8'h00);
        rd(8'h24, 8'h00);
        rd(8'h28, 8'h10);
        rd(8'h2C, 9'h1FF);
        rd(8'h30, 8'h00);
    endtask
    task automatic t_flags();
        wr(8'h0C, 8'hF0);
        wr(8'h10, 8'h30);
        rd(8'h10, 8'hC0);
        wr(8'h14, 8'h03);
        fset <= 32'h0000_0100;
        @(posedge clk);
        fset <= 32'h0000_0000;
        rd(8'h14, 9'h1C3);
        fclr <= 32'h0000_01C3;
        @(posedge clk);
        fclr <= 32'h0000_0000;
        rd(8'h0C, 8'h00);
    endtask
    task automatic t_irq();
        wr(8'h28, 8'h03);
        wr(8'h20, 8'h06);
        wr(8'h1C, 8'h04);
        rd(8'h18, 8'h02);
        wr(8'h18, 8'h01);
        wr(8'h14, 8'h01);
        repeat (5) @(posedge clk);
        check("level irq", {31'h0, irq}, 1);
        wr(8'h18, 8'h00);
        repeat (5) @(posedge clk);
        check("masked irq", {31'h0, irq}, 0);
        wr(8'h10, 8'h01);
        wr(8'h24, 8'h01);
        wr(8'h18, 8'h01);
        wr(8'h14, 8'h01);
        n = 0;
        repeat (10) begin
            @(posedge clk);
            if (irq === 1'b1) n++;
        end
        check("pulse cycles", 32'(n), 3);
    endtask
    task automatic t_shadow();
        running <= 1'b1;
        wr(8'h00, 32'h1234_5601);
        @(posedge clk);
        check("write pulse", {31'h0, cmd_wr}, 1);
        rd(8'h00, 32'h1234_5601);
        check("held command", cmd_word, 32'h0000_00FF);
        wr(8'h3C, 32'hA5A5_0001);
        rd(8'h3C, 32'hA5A5_0001);
        wr(8'h38, 8'h01);
        rd(8'h3C, 8'h00);
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        repeat (2) @(posedge clk);
        check("started command", cmd_word, 32'h1234_5601);
        rd(8'h3C, 32'hA5A5_0001);
        lock <= 1'b1;
        wr(8'h3C, 8'h77);
        lock <= 1'b0;
        running <= 1'b0;
        repeat (3) @(posedge clk);
        check("locked param", eparam, 32'hA5A5_0001);
    endtask
    task automatic t_fifo();
        in_rdy <= 1'b1;
        out_vld <= 1'b1;
        out_data <= 32'h1357_9BDF;
        wr(8'h04, 32'hCAFE_0001);
        rd(8'h08, 32'h1357_9BDF);
        rd(8'h04, 8'h00, 1);
        wr(8'h08, 8'h01, 1);
        u_host.strb = 4'h3;
        wr(8'h04, 8'h02, 1);
        u_host.strb = 4'hF;
        wr(8'h0C, 8'h00);
        wr(8'h2C, 12'h105);
        in_rdy <= 1'b0;
        wr(8'h04, 8'h03, 1);
        rd(8'h30, 8'h04);
        rd(8'h0C, 8'h04);
    endtask
    task automatic wrap_up();
        if (num_errors == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    initial begin
        forever #20 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        wrap_up();
    end
    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_flags();
        t_irq();
        t_shadow();
        t_fifo();
        wrap_up();
    end
endmodule

bind hbc_regs hbc_regs_properties u_props (.*);
